// *** design/afsc_cfg.svh ***
// Constants shared by both ends of the front-end source control link.
`ifndef AFSC_CFG_SVH
`define AFSC_CFG_SVH

`define AFSC_CFG_INDEX_W      2
`define AFSC_CFG_DATA_W       8
`define AFSC_IDX_SENSE        2'h0
`define AFSC_IDX_REFCTL       2'h1
`define AFSC_IDX_MAGNITUDE    2'h2
`define AFSC_IDX_ROUTE        2'h3
`define AFSC_BURNOUT_BIT      0
`define AFSC_REFSEL_LSB       0
`define AFSC_BRIDGE_BIT       3
`define AFSC_MAG_LSB          0
`define AFSC_ROUTE1_LSB       0
`define AFSC_ROUTE2_LSB       3
`define AFSC_SENSE_RESET      8'h00
`define AFSC_REFCTL_RESET     8'h00
`define AFSC_MAGNITUDE_RESET  8'h00
`define AFSC_ROUTE_RESET      8'h00
`define AFSC_CONV_CYCLES      1000
`define AFSC_EDGES_TO_SWITCH  2
`define AFSC_CLOCK_MHZ        100
`define AFSC_REF_SETTLE_US    25
`define AFSC_EXC_STARTUP_US   200
`define AFSC_OFS_COMMAND      32'h0000_0000
`define AFSC_OFS_SENSE        32'h0000_0004
`define AFSC_OFS_REFCTL       32'h0000_0008
`define AFSC_OFS_MAGNITUDE    32'h0000_000C
`define AFSC_OFS_ROUTE        32'h0000_0010
`define AFSC_OFS_STATUS       32'h0000_0014
`define AFSC_ST_EXTCLK_BIT    0
`define AFSC_ST_BUSY_BIT      1
`define AFSC_ST_DONE_BIT      2
`define AFSC_ST_REFOK_BIT     3
`define AFSC_ST_EXCOK_BIT     4
`define AFSC_ST_PEND_BIT      5

`endif

// *** design/afsc_pkg.sv ***
// Types shared by both ends of the front-end source control link.
package afsc_pkg;
	typedef enum logic [1:0] {
		REF_INTERNAL = 2'b00,
		REF_PAIR0    = 2'b01,
		REF_PAIR1    = 2'b10,
		REF_SUPPLY   = 2'b11
	} afsc_ref_type;

	typedef enum logic [1:0] {
		CMD_NONE  = 2'b00,
		CMD_START = 2'b01,
		CMD_SLEEP = 2'b10,
		CMD_RESET = 2'b11
	} afsc_cmd_type;

	typedef enum logic [1:0] {
		CLK_INTERNAL = 2'b00,
		CLK_ONE_EDGE = 2'b01,
		CLK_EXTERNAL = 2'b10
	} afsc_clk_type;
endpackage

// *** design/afsc_link_if.sv ***
// Link between the host controller and the converter front-end control.
`timescale 1ns/1ps
interface afsc_link_if;
	logic                 cfgWrite;
	logic [1:0]           cfgIndex;
	logic [7:0]           cfgData;
	logic                 cmdValid;
	afsc_pkg::afsc_cmd_type cmdCode;
	logic                 extClockActive;
	logic                 converting;
	logic                 convDone;

	modport device (input cfgWrite, input cfgIndex, input cfgData, input cmdValid,
		input cmdCode, output extClockActive, output converting, output convDone);
	modport host (output cfgWrite, output cfgIndex, output cfgData, output cmdValid,
		output cmdCode, input extClockActive, input converting, input convDone);
endinterface

// *** design/afsc_device.sv ***
// Front-end source control of the converter: reference, clock, excitation, switch.
`timescale 1ns/1ps
`include "afsc_cfg.svh"

// Operation
// - two-bit field selects reference source
// - reset selects internal reference
// - host waits 25 us reference settling
// - pair one reuses analog inputs zero, three
// - grounded clock pin keeps internal oscillator
// - two rising edges switch to external
// - only reset returns to internal oscillator
// - three-bit field sets excitation magnitude
// - each source routed by own field
// - host waits 200 us excitation startup
// - host writes magnitude before routing
// - nonzero magnitude keeps sources on between conversions
// - sleep powers down both excitation sources
// - switch closes on start, opens sleep
// - switch stays closed between single-shot conversions
// - clearing enable opens switch; reset open
// - burn-out sources feed selected inputs
// - host enables burn-out only for fault tests
// - external clock must be 4.096 MHz
// - one conversion per trigger, then idle
module afsc_device #(
	parameter int CONV_CYCLES = `AFSC_CONV_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        reset,
	afsc_link_if.device      link,
	input  wire logic        extClockPin,
	output afsc_pkg::afsc_ref_type refSelect,
	output logic             analogInputZeroIsRef,
	output logic             analogInputThreeIsRef,
	output logic             internalOscEnable,
	output logic             systemClockExternal,
	output logic [2:0]       excitationMagnitude,
	output logic [2:0]       excitation1Route,
	output logic [2:0]       excitation2Route,
	output logic             excitationPowered,
	output logic             bridgeSwitchClosed,
	output logic             burnoutSourcePositive,
	output logic             burnoutSinkNegative,
	output logic             conversionActive
);
	localparam int CW = $clog2(CONV_CYCLES + 1);

	logic [7:0]             senseReg_q;
	logic [7:0]             refCtlReg_q;
	logic [7:0]             magnitudeReg_q;
	logic [7:0]             routeReg_q;
	logic                   softReset;
	logic                   startCmd;
	logic                   sleepCmd;
	afsc_pkg::afsc_clk_type clkState_q;
	logic                   pinPrev_q;
	logic                   primed_q;
	logic                   pinRise;
	logic                   asleep_q;
	logic                   switchClosed_q;
	logic                   busy_q;
	logic [CW-1:0]          convCount_q;
	logic                   done_q;
	logic                   bridgeEnable;

	// Command decode; an idle strobe or the empty code triggers nothing.
	always_comb begin
		softReset = 1'b0;
		startCmd  = 1'b0;
		sleepCmd  = 1'b0;
		if (link.cmdValid) begin
			case (link.cmdCode)
				afsc_pkg::CMD_START: startCmd  = 1'b1;
				afsc_pkg::CMD_SLEEP: sleepCmd  = 1'b1;
				afsc_pkg::CMD_RESET: softReset = 1'b1;
				default:             startCmd  = 1'b0;
			endcase
		end
	end
	assign bridgeEnable = refCtlReg_q[`AFSC_BRIDGE_BIT];

	// Configuration storage; a reset command restores defaults too.
	always_ff @(posedge clock) begin
		if (reset || softReset) begin
			senseReg_q     <= `AFSC_SENSE_RESET;
			refCtlReg_q    <= `AFSC_REFCTL_RESET;
			magnitudeReg_q <= `AFSC_MAGNITUDE_RESET;
			routeReg_q     <= `AFSC_ROUTE_RESET;
		end else if (link.cfgWrite) begin
			case (link.cfgIndex)
				`AFSC_IDX_SENSE:     senseReg_q     <= link.cfgData;
				`AFSC_IDX_REFCTL:    refCtlReg_q    <= link.cfgData;
				`AFSC_IDX_MAGNITUDE: magnitudeReg_q <= link.cfgData;
				`AFSC_IDX_ROUTE:     routeReg_q     <= link.cfgData;
				default:             senseReg_q     <= senseReg_q;
			endcase
		end
	end

	assign refSelect = afsc_pkg::afsc_ref_type'(refCtlReg_q[`AFSC_REFSEL_LSB +: 2]);
	// The second reference pair shares its pins with two analog inputs.
	assign analogInputZeroIsRef  = refSelect == afsc_pkg::REF_PAIR1;
	assign analogInputThreeIsRef = refSelect == afsc_pkg::REF_PAIR1;

	// Clock pin edge detection. The first sample after reset only primes the
	// history so that a pin already high at release is not taken as an edge.
	always_ff @(posedge clock) begin
		if (reset) begin
			pinPrev_q <= 1'b0;
			primed_q  <= 1'b0;
		end else begin
			pinPrev_q <= extClockPin;
			primed_q  <= 1'b1;
		end
	end
	assign pinRise = primed_q && extClockPin && !pinPrev_q;

	// Any two rising edges count, however far apart, so a single glitch on an
	// idle pin leaves the device one edge away from changing clocks.
	always_ff @(posedge clock) begin
		if (reset || softReset) begin
			clkState_q <= afsc_pkg::CLK_INTERNAL;
		end else begin
			case (clkState_q)
				afsc_pkg::CLK_INTERNAL: begin
					if (pinRise) begin
						clkState_q <= afsc_pkg::CLK_ONE_EDGE;
					end
				end
				afsc_pkg::CLK_ONE_EDGE: begin
					if (pinRise) begin
						clkState_q <= afsc_pkg::CLK_EXTERNAL;
					end
				end
				afsc_pkg::CLK_EXTERNAL: clkState_q <= afsc_pkg::CLK_EXTERNAL;
				default: clkState_q <= afsc_pkg::CLK_INTERNAL;
			endcase
		end
	end
	assign systemClockExternal = clkState_q == afsc_pkg::CLK_EXTERNAL;
	assign internalOscEnable   = !systemClockExternal;
	assign link.extClockActive = systemClockExternal;

	// Single-shot conversion: a start or any configuration write restarts it.
	// Busy stands for exactly CONV_CYCLES cycles; done follows in the next one.
	always_ff @(posedge clock) begin
		if (reset || softReset || sleepCmd) begin
			busy_q      <= 1'b0;
			convCount_q <= '0;
		end else if (startCmd || link.cfgWrite) begin
			busy_q      <= 1'b1;
			convCount_q <= CW'(CONV_CYCLES - 1);
		end else if (busy_q) begin
			if (convCount_q == '0) begin
				busy_q <= 1'b0;
			end else begin
				convCount_q <= convCount_q - CW'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset || softReset) begin
			done_q <= 1'b0;
		end else begin
			// A restart or sleep in the final cycle cancels the pulse of the old run.
			done_q <= busy_q && convCount_q == '0 && !startCmd && !link.cfgWrite && !sleepCmd;
		end
	end
	assign conversionActive = busy_q;
	assign link.converting  = busy_q;
	assign link.convDone    = done_q;

	always_ff @(posedge clock) begin
		if (reset || softReset) begin
			asleep_q <= 1'b0;
		end else if (sleepCmd) begin
			asleep_q <= 1'b1;
		end else if (startCmd) begin
			asleep_q <= 1'b0;
		end
	end

	assign excitationMagnitude = magnitudeReg_q[`AFSC_MAG_LSB +: 3];
	assign excitation1Route    = routeReg_q[`AFSC_ROUTE1_LSB +: 3];
	assign excitation2Route    = routeReg_q[`AFSC_ROUTE2_LSB +: 3];
	// Sources stay on between conversions; only sleep or code zero stops them.
	assign excitationPowered = excitationMagnitude != 3'h0 && !asleep_q;

	always_ff @(posedge clock) begin
		if (reset || softReset) begin
			switchClosed_q <= 1'b0;
		end else if (sleepCmd) begin
			switchClosed_q <= 1'b0;
		end else if (!bridgeEnable) begin
			// Dropping the enable forgets the closed state, so a later re-enable
			// waits for the next start instead of closing the switch by itself.
			switchClosed_q <= 1'b0;
		end else if (startCmd && bridgeEnable) begin
			switchClosed_q <= 1'b1;
		end
	end
	// Gated by the live enable so that clearing it opens the switch at once.
	assign bridgeSwitchClosed = switchClosed_q && bridgeEnable;

	assign burnoutSourcePositive = senseReg_q[`AFSC_BURNOUT_BIT];
	assign burnoutSinkNegative   = senseReg_q[`AFSC_BURNOUT_BIT];
endmodule

// *** design/afsc_host.sv ***
// Host controller: AHB-Lite registers that drive the front-end control link.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "afsc_cfg.svh"

module afsc_host #(
	parameter int EXC_STARTUP_CYCLES = `AFSC_EXC_STARTUP_US * `AFSC_CLOCK_MHZ
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	afsc_link_if.host        link
);
	localparam int REF_SETTLE_CYCLES = `AFSC_REF_SETTLE_US * `AFSC_CLOCK_MHZ;
	localparam int RW = $clog2(REF_SETTLE_CYCLES + 1);
	localparam int EW = $clog2(EXC_STARTUP_CYCLES + 1);

	logic              addrValid_q;
	logic              addrWrite_q;
	logic [31:0]       addrReg_q;
	logic              readWait_q;
	logic [31:0]       rdata_q;
	logic              wrPhase;
	logic [7:0]        shadow_q [4];
	logic              cmdWrite;
	afsc_pkg::afsc_cmd_type reqCmd;
	logic              pendStart_q;
	logic              asleep_q;
	logic [RW-1:0]     refCount_q;
	logic [EW-1:0]     excCount_q;
	logic              done_q;
	logic              cfgWr_q;
	logic [1:0]        cfgIdx_q;
	logic [7:0]        cfgDat_q;
	logic              cmdV_q;
	afsc_pkg::afsc_cmd_type cmd_q;
	logic              refOk;
	logic              excOk;
	logic              cfgHit;
	logic [1:0]        cfgSlot;

	always_ff @(posedge clock) begin
		if (reset) begin
			addrValid_q <= 1'b0;
			addrWrite_q <= 1'b0;
			addrReg_q   <= 32'h0000_0000;
		end else if (hready) begin
			addrValid_q <= hsel && htrans[1];
			addrWrite_q <= hwrite;
			addrReg_q   <= haddr;
		end
	end

	// Reads take one wait state so a read right after a write sees the new value.
	always_ff @(posedge clock) begin
		if (reset) begin
			readWait_q <= 1'b0;
		end else begin
			readWait_q <= addrValid_q && !addrWrite_q && !readWait_q;
		end
	end
	assign hreadyout = !(addrValid_q && !addrWrite_q && !readWait_q);
	assign hresp     = 1'b0;
	assign wrPhase   = addrValid_q && addrWrite_q;
	assign cfgHit    = addrReg_q >= `AFSC_OFS_SENSE && addrReg_q <= `AFSC_OFS_ROUTE
		&& addrReg_q[1:0] == 2'h0;
	assign cfgSlot   = 2'(addrReg_q[4:2] - 3'h1);
	assign cmdWrite  = wrPhase && addrReg_q == `AFSC_OFS_COMMAND;
	assign reqCmd    = afsc_pkg::afsc_cmd_type'(hwdata[1:0]);
	assign refOk     = refCount_q == '0;
	assign excOk     = excCount_q == '0;

	always_ff @(posedge clock) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				shadow_q[i] <= 8'h00;
			end
		end else if (cmdWrite && reqCmd == afsc_pkg::CMD_RESET) begin
			for (int i = 0; i < 4; i++) begin
				shadow_q[i] <= 8'h00;
			end
		end else if (wrPhase && cfgHit) begin
			shadow_q[cfgSlot] <= hwdata[7:0];
		end
	end

	// Writes reach the device in bus order, so software that writes magnitude
	// before routing gets that order on the link too.
	always_ff @(posedge clock) begin
		if (reset) begin
			cfgWr_q  <= 1'b0;
			cfgIdx_q <= 2'h0;
			cfgDat_q <= 8'h00;
		end else begin
			cfgWr_q  <= wrPhase && cfgHit;
			cfgIdx_q <= cfgSlot;
			cfgDat_q <= hwdata[7:0];
		end
	end

	// A start is held back until both settling windows have run out.
	always_ff @(posedge clock) begin
		if (reset) begin
			pendStart_q <= 1'b0;
			cmdV_q      <= 1'b0;
			cmd_q       <= afsc_pkg::CMD_NONE;
		end else if (cmdWrite && reqCmd != afsc_pkg::CMD_NONE
			&& reqCmd != afsc_pkg::CMD_START) begin
			pendStart_q <= 1'b0;
			cmdV_q      <= 1'b1;
			cmd_q       <= reqCmd;
		end else if ((pendStart_q || (cmdWrite && reqCmd == afsc_pkg::CMD_START))
			&& refOk && excOk && !asleep_q) begin
			pendStart_q <= 1'b0;
			cmdV_q      <= 1'b1;
			cmd_q       <= afsc_pkg::CMD_START;
		end else begin
			pendStart_q <= pendStart_q || (cmdWrite && reqCmd == afsc_pkg::CMD_START);
			cmdV_q      <= 1'b0;
			cmd_q       <= afsc_pkg::CMD_NONE;
		end
	end

	// Leaving sleep restarts reference settling before the start goes out.
	always_ff @(posedge clock) begin
		if (reset) begin
			asleep_q <= 1'b0;
		end else if (cmdV_q && cmd_q == afsc_pkg::CMD_SLEEP) begin
			asleep_q <= 1'b1;
		end else if (asleep_q && pendStart_q) begin
			asleep_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset || (cmdV_q && cmd_q == afsc_pkg::CMD_RESET)) begin
			refCount_q <= RW'(REF_SETTLE_CYCLES);
		end else if (asleep_q && pendStart_q) begin
			refCount_q <= RW'(REF_SETTLE_CYCLES);
		end else if (wrPhase && cfgHit && cfgSlot == `AFSC_IDX_REFCTL
			&& hwdata[1:0] == afsc_pkg::REF_INTERNAL
			&& shadow_q[`AFSC_IDX_REFCTL][1:0] != afsc_pkg::REF_INTERNAL) begin
			// Judged in the data phase, while the shadow still holds the old select.
			refCount_q <= RW'(REF_SETTLE_CYCLES);
		end else if (!refOk) begin
			refCount_q <= refCount_q - RW'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			excCount_q <= '0;
		end else if (cfgWr_q && cfgIdx_q == `AFSC_IDX_MAGNITUDE
			&& cfgDat_q[2:0] != 3'h0) begin
			excCount_q <= EW'(EXC_STARTUP_CYCLES);
		end else if (!excOk) begin
			excCount_q <= excCount_q - EW'(1);
		end
	end

	// Conversion-done flag: a new completion wins over a write-one clear.
	always_ff @(posedge clock) begin
		if (reset) begin
			done_q <= 1'b0;
		end else if (link.convDone) begin
			done_q <= 1'b1;
		end else if (wrPhase && addrReg_q == `AFSC_OFS_STATUS && hwdata[`AFSC_ST_DONE_BIT]) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_q <= 32'h0000_0000;
		end else if (addrValid_q && !addrWrite_q && !readWait_q) begin
			rdata_q <= 32'h0000_0000;
			if (cfgHit) begin
				rdata_q[7:0] <= shadow_q[cfgSlot];
			end else if (addrReg_q == `AFSC_OFS_STATUS) begin
				rdata_q[5:0] <= {pendStart_q, excOk, refOk, done_q,
					link.converting, link.extClockActive};
			end
		end
	end
	assign hrdata = rdata_q;

	assign link.cfgWrite = cfgWr_q;
	assign link.cfgIndex = cfgIdx_q;
	assign link.cfgData  = cfgDat_q;
	assign link.cmdValid = cmdV_q;
	assign link.cmdCode  = cmd_q;
endmodule

// *** dv/afsc_checker.sv ***
// Assertions on the link between the host controller and the front-end control.
`timescale 1ns/1ps
module afsc_checker #(
	parameter int CONV_CYCLES = 20
) (
	input logic                   clock,
	input logic                   reset,
	input logic                   cfgWrite,
	input logic [1:0]             cfgIndex,
	input logic [7:0]             cfgData,
	input logic                   cmdValid,
	input afsc_pkg::afsc_cmd_type cmdCode,
	input logic                   extClockActive,
	input logic                   converting,
	input logic                   convDone
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	logic        startCmd;
	logic        sleepCmd;
	logic        resetCmd;
	logic [15:0] sinceStart_q;
	logic        untouched_q;
	assign startCmd = cmdValid && cmdCode == afsc_pkg::CMD_START;
	assign sleepCmd = cmdValid && cmdCode == afsc_pkg::CMD_SLEEP;
	assign resetCmd = cmdValid && cmdCode == afsc_pkg::CMD_RESET;

	always_ff @(posedge clock) begin
		if (reset || startCmd) begin
			sinceStart_q <= 16'h0000;
		end else if (sinceStart_q != 16'hFFFF) begin
			sinceStart_q <= sinceStart_q + 16'h0001;
		end
	end

	// A config write or another command restarts or ends a run, so only untouched runs are timed.
	always_ff @(posedge clock) begin
		if (reset) begin
			untouched_q <= 1'b0;
		end else if (startCmd) begin
			untouched_q <= 1'b1;
		end else if (cfgWrite || cmdValid) begin
			untouched_q <= 1'b0;
		end
	end

	sequence s_start;
		cmdValid && cmdCode == afsc_pkg::CMD_START;
	endsequence
	sequence s_quiet_run;
		converting && !convDone && !cmdValid && !cfgWrite;
	endsequence

	a_start_sets_conv: assert property (s_start |=> converting)
		else $error("converting did not rise after a start");
	a_sleep_stops_conv: assert property (sleepCmd |=> !converting)
		else $error("converting still high after sleep");
	a_reset_cmd_clears: assert property (resetCmd |=> !extClockActive && !converting)
		else $error("reset command left clock or conversion state");
	a_ext_clock_sticky: assert property (extClockActive && !resetCmd |=> extClockActive)
		else $error("external clock dropped without reset");
	a_done_single_pulse: assert property (convDone |=> !convDone)
		else $error("done pulse longer than one cycle");
	a_done_exact_time: assert property (convDone && untouched_q |->
		sinceStart_q == 16'(CONV_CYCLES))
		else $error("done pulse at the wrong cycle");
	a_cmd_code_set: assert property (cmdValid |-> cmdCode != afsc_pkg::CMD_NONE)
		else $error("command strobe without a code");
	a_reset_quiet: assert property ($fell(reset) |-> !extClockActive && !converting)
		else $error("link not idle after reset");
	a_conv_holds: assert property (s_quiet_run |=> converting || convDone)
		else $error("conversion ended without done");
endmodule

// *** dv/afsc_test.sv ***
// Self-checking bench joining the host controller and the device over the link.
`timescale 1ns/1ps
`include "afsc_cfg.svh"
module afsc_test;
	logic                   clock = 1'b0;
	logic                   reset = 1'b1;
	logic                   hsel = 1'b0;
	logic [31:0]            haddr = 32'h0000_0000;
	logic [1:0]             htrans = 2'h0;
	logic                   hwrite = 1'b0;
	logic [31:0]            hwdata = 32'h0000_0000;
	logic                   hready;
	logic [31:0]            hrdata;
	logic                   hresp;
	logic                   extClockPin = 1'b0;
	afsc_pkg::afsc_ref_type refSelect;
	logic                   zeroIsRef, threeIsRef, oscOn, clkExt, excPow;
	logic                   swClosed, boSrc, boSnk, convAct;
	logic [2:0]             mag, r1, r2;
	int                     numErrors = 0;
	int                     cmpCount = 0;

	always #5 clock = ~clock;

	afsc_link_if afsc_link_if_i ();
	afsc_host #(.EXC_STARTUP_CYCLES(50)) afsc_host_i (.clock(clock), .reset(reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.link(afsc_link_if_i));
	afsc_device #(.CONV_CYCLES(20)) afsc_device_i (.clock(clock), .reset(reset),
		.link(afsc_link_if_i), .extClockPin(extClockPin), .refSelect(refSelect),
		.analogInputZeroIsRef(zeroIsRef), .analogInputThreeIsRef(threeIsRef),
		.internalOscEnable(oscOn), .systemClockExternal(clkExt), .excitationMagnitude(mag),
		.excitation1Route(r1), .excitation2Route(r2), .excitationPowered(excPow),
		.bridgeSwitchClosed(swClosed), .burnoutSourcePositive(boSrc),
		.burnoutSinkNegative(boSnk), .conversionActive(convAct));
	afsc_checker #(.CONV_CYCLES(20)) afsc_checker_i (.clock(clock), .reset(reset),
		.cfgWrite(afsc_link_if_i.cfgWrite), .cfgIndex(afsc_link_if_i.cfgIndex),
		.cfgData(afsc_link_if_i.cfgData), .cmdValid(afsc_link_if_i.cmdValid),
		.cmdCode(afsc_link_if_i.cmdCode), .extClockActive(afsc_link_if_i.extClockActive),
		.converting(afsc_link_if_i.converting), .convDone(afsc_link_if_i.convDone));

	task automatic closeOut();
		if (numErrors == 0 && cmpCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			numErrors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Outputs are sampled at the falling edge, where the next rising edge will see them.
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(negedge clock); while (hready !== 1'b1);
		@(posedge clock);
		htrans <= 2'h0;
		hwdata <= d;
		do @(negedge clock); while (hready !== 1'b1);
		q = hrdata;
		@(posedge clock);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check(q, e);
		check(32'(hresp), 32'h0);
	endtask

	task automatic waitBit(input int b);
		logic [31:0] q;
		int          n;
		n = 0;
		do begin
			bus(1'b0, `AFSC_OFS_STATUS, 32'h0000_0000, q);
			n++;
		end while (q[b] !== 1'b1 && n < 2000);
		check(32'(q[b]), 32'h1);
	endtask

	task automatic waitDone();
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (afsc_link_if_i.convDone !== 1'b1 && n < 200);
		check(32'(afsc_link_if_i.convDone), 32'h1);
	endtask

	initial begin
		#200000;
		numErrors++;
		closeOut();
	end

	initial begin
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		tick(2);
		check(32'(refSelect), 32'h0);
		check(32'(swClosed), 32'h0);
		check(32'(oscOn), 32'h1);
		rdc(`AFSC_OFS_REFCTL, 32'h0);
		rdc(32'h0000_0040, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(`AFSC_OFS_REFCTL, 32'(i));
			tick(3);
			check(32'(refSelect), 32'(i));
			check(32'({zeroIsRef, threeIsRef}), i == 2 ? 32'h3 : 32'h0);
			rdc(`AFSC_OFS_REFCTL, 32'(i));
		end
		for (int m = 1; m < 8; m++) begin
			wr(`AFSC_OFS_MAGNITUDE, 32'(m % 7));
			tick(3);
			check(32'(mag), 32'(m % 7));
			check(32'(excPow), 32'(m != 7));
		end
		for (int k = 0; k < 2; k++) begin
			wr(`AFSC_OFS_ROUTE, k ? 32'h3A : 32'h2D);
			tick(3);
			check(32'({r2, r1}), k ? 32'h3A : 32'h2D);
		end
		for (int b = 1; b >= 0; b--) begin
			wr(`AFSC_OFS_SENSE, 32'(b));
			tick(3);
			check(32'({boSrc, boSnk}), b ? 32'h3 : 32'h0);
		end
		wr(`AFSC_OFS_REFCTL, 32'h08);
		wr(`AFSC_OFS_MAGNITUDE, 32'h3);
		waitBit(3);
		waitBit(4);
		wr(`AFSC_OFS_COMMAND, 32'h1);
		waitDone();
		tick(3);
		check(32'({swClosed, excPow, convAct}), 32'h6);
		rdc(`AFSC_OFS_STATUS, 32'h1C);
		wr(`AFSC_OFS_STATUS, 32'h4);
		rdc(`AFSC_OFS_STATUS, 32'h18);
		wr(`AFSC_OFS_REFCTL, 32'h0);
		tick(3);
		check(32'(swClosed), 32'h0);
		wr(`AFSC_OFS_REFCTL, 32'h08);
		tick(3);
		check(32'(swClosed), 32'h0);
		wr(`AFSC_OFS_COMMAND, 32'h1);
		waitBit(1);
		tick(2);
		check(32'(swClosed), 32'h1);
		wr(`AFSC_OFS_COMMAND, 32'h2);
		tick(3);
		check(32'({swClosed, excPow, convAct}), 32'h0);
		// The pin runs near 4.096 MHz, as close as the 10 ns sampling clock allows.
		for (int e = 0; e < 3; e++) begin
			check(32'({clkExt, oscOn}), e == 2 ? 32'h2 : 32'h1);
			@(posedge clock);
			extClockPin <= 1'b1;
			tick(12);
			@(posedge clock);
			extClockPin <= 1'b0;
			tick(12);
		end
		rdc(`AFSC_OFS_STATUS, 32'h19);
		wr(`AFSC_OFS_REFCTL, 32'h1);
		wr(`AFSC_OFS_REFCTL, 32'h0);
		rdc(`AFSC_OFS_STATUS, 32'h13);
		wr(`AFSC_OFS_COMMAND, 32'h3);
		tick(3);
		check(32'({clkExt, oscOn}), 32'h1);
		check(32'(refSelect), 32'h0);
		closeOut();
	end
endmodule
